/* File: design/dma_align_pkg.sv */
// Constants, types and register map of the DMA alignment sequencer
// Function
// - Incrementing byte/short/word transfers accept any address, count
// - Incrementing or sub-quad block mode: one-byte count granularity
// - Byte requests until aligned, then programmed, bytes finish
// - Source may be reread while aligning; tolerate it
// - One acknowledge per request; requester paces from acknowledge
// - Short/word mixed pairings use byte requests when unaligned
// - Listed pairings keep alignment optimisation on unaligned blocks
// - Demand modes also run fully unaligned
// - Acknowledge held for whole resulting bus request
// - Fly-by leaves data bus undriven
package dma_align_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SRC_OFS  = 8'h04;
    localparam logic [7:0] DST_OFS  = 8'h08;
    localparam logic [7:0] CNT_OFS  = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] ACKS_OFS = 8'h14;

    // Control field positions
    localparam int unsigned CTRL_START_BIT  = 0;
    localparam int unsigned CTRL_DEMAND_BIT = 1;
    localparam int unsigned CTRL_FLYBY_BIT  = 2;
    localparam int unsigned CTRL_SRCSYN_BIT = 3;
    localparam int unsigned CTRL_SLEN_LSB   = 4;
    localparam int unsigned CTRL_DLEN_LSB   = 6;
    localparam int unsigned CTRL_SFIX_BIT   = 8;
    localparam int unsigned CTRL_DFIX_BIT   = 9;
    localparam int unsigned CTRL_FLYST_BIT  = 10;
    localparam int unsigned CTRL_WIDTH      = 11;

    // Status field positions
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_DONE_BIT = 1;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] CNT_RST  = 32'h0000_0000;

    // Request length codes
    typedef enum logic [1:0] {
        LEN_BYTE  = 2'h0,
        LEN_SHORT = 2'h1,
        LEN_WORD  = 2'h2,
        LEN_QUAD  = 2'h3
    } len_e;

    localparam logic [4:0] STEP_BYTE = 5'h01;
    localparam logic [4:0] STEP_QUAD = 5'h10;

    // Bus request towards the bus controller
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        flyby;
        logic [31:0] addr;
        logic [4:0]  bytes;
    } bus_req_s;

endpackage

/* File: design/dma_step_calc.sv */
// Chooses the byte size of the next bus request
`timescale 1ns/1ps
module dma_step_calc
    import dma_align_pkg::*;
(
    // Configuration
    input  wire len_e        src_len_i,
    input  wire len_e        dst_len_i,
    input  wire logic        flyby_i,
    input  wire logic        no_opt_i,
    // Progress
    input  wire logic [3:0]  src_off_i,
    input  wire logic [3:0]  dst_off_i,
    input  wire logic [31:0] count_i,
    // Result
    output logic      [4:0]  step_o
);

    len_e       base;
    logic [4:0] full;
    logic [3:0] mask;

    always_comb begin
        base = (src_len_i < dst_len_i) ? src_len_i : dst_len_i;
        full = (base == LEN_QUAD) ? STEP_QUAD : 5'(5'h01 << base);
        mask = 4'(full - 5'h01);
        if (flyby_i) begin
            step_o = (src_len_i == LEN_QUAD) ? STEP_QUAD : 5'(5'h01 << src_len_i);
        end else if (base == LEN_QUAD) begin
            step_o = STEP_QUAD;
        end else if (no_opt_i) begin
            step_o = STEP_BYTE;
        end else if (((src_off_i & mask) == 4'h0) && ((dst_off_i & mask) == 4'h0)
                     && (count_i >= 32'(full))) begin
            step_o = full;
        end else begin
            step_o = STEP_BYTE;
        end
    end

endmodule

/* File: design/dma_addr_track.sv */
// Address register that holds or advances after each request
`timescale 1ns/1ps
module dma_addr_track
    import dma_align_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Control
    input  wire logic        load_i,
    input  wire logic [31:0] load_val_i,
    input  wire logic        adv_i,
    input  wire logic        fixed_i,
    input  wire logic [4:0]  step_i,
    // Current address
    output logic      [31:0] addr_o
);

    logic [31:0] addr_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_r <= ADDR_RST;
        end else if (load_i) begin
            addr_r <= load_val_i;
        end else if (adv_i && !fixed_i) begin
            addr_r <= addr_r + 32'(step_i);
        end
    end

    assign addr_o = addr_r;

endmodule

/* File: design/dma_align_seq.sv */
// DMA channel alignment sequencer with APB registers
`timescale 1ns/1ps
module dma_align_seq
    import dma_align_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // APB slave
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [7:0]   paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    // Peripheral handshake
    input  wire logic         dma_request_line_i,
    output logic              dma_acknowledge_line_o,
    // Bus controller
    output bus_req_s          bus_req_o,
    input  wire logic         bus_done_i,
    input  wire logic [127:0] bus_rdata_i,
    output logic      [127:0] bus_wdata_o,
    output logic              bus_data_oe_o
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_PICK,
        S_WAIT,
        S_LOAD,
        S_STORE,
        S_FLY
    } state_e;

    state_e       state_r;
    logic [CTRL_WIDTH-1:0] ctrl_r;
    logic [31:0]  src_cfg_r;
    logic [31:0]  dst_cfg_r;
    logic [31:0]  count_r;
    logic [31:0]  acks_r;
    logic         done_r;
    logic         armed_r;
    logic         wait_store_r;
    logic         no_opt_r;
    logic [4:0]   step_r;
    logic [127:0] hold_r;

    logic         apb_acc;
    logic         apb_wr;
    logic         start;
    logic         busy;
    logic [31:0]  src_addr;
    logic [31:0]  dst_addr;
    logic [4:0]   step_next;
    logic         xfer_end;
    logic         demand;
    logic         flyby;
    logic         src_sync;
    len_e         src_len;
    len_e         dst_len;
    logic         ack_phase;
    logic         req_take;
    logic [255:0] rot_in;
    logic [255:0] rot_out;
    logic [3:0]   blk_mask;
    len_e         new_slen;
    len_e         new_dlen;

    assign demand   = ctrl_r[CTRL_DEMAND_BIT];
    assign flyby    = ctrl_r[CTRL_FLYBY_BIT];
    assign src_sync = ctrl_r[CTRL_SRCSYN_BIT];
    assign src_len  = len_e'(ctrl_r[CTRL_SLEN_LSB +: 2]);
    assign dst_len  = len_e'(ctrl_r[CTRL_DLEN_LSB +: 2]);
    assign busy     = (state_r != S_IDLE);

    // APB: zero wait states, unmapped offsets answer with an error
    assign apb_acc   = psel_i && penable_i;
    assign apb_wr    = apb_acc && pwrite_i;
    assign pready_o  = 1'b1;
    assign start     = apb_wr && (paddr_i == CTRL_OFS) && pwdata_i[CTRL_START_BIT] && !busy;

    always_comb begin
        pslverr_o = 1'b0;
        prdata_o  = 32'h0000_0000;
        case (paddr_i)
            CTRL_OFS: prdata_o = {21'h000000, ctrl_r};
            SRC_OFS:  prdata_o = src_addr;
            DST_OFS:  prdata_o = dst_addr;
            CNT_OFS:  prdata_o = count_r;
            STAT_OFS: prdata_o = {30'h00000000, done_r, busy};
            ACKS_OFS: prdata_o = acks_r;
            default:  pslverr_o = apb_acc;
        endcase
    end

    // Configuration is frozen while a transfer runs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= CTRL_RST[CTRL_WIDTH-1:0];
        end else if (apb_wr && !busy && paddr_i == CTRL_OFS) begin
            ctrl_r <= {pwdata_i[CTRL_WIDTH-1:1], 1'b0};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_cfg_r <= ADDR_RST;
            dst_cfg_r <= ADDR_RST;
        end else if (apb_wr && !busy) begin
            if (paddr_i == SRC_OFS) begin
                src_cfg_r <= pwdata_i;
            end
            if (paddr_i == DST_OFS) begin
                dst_cfg_r <= pwdata_i;
            end
        end
    end

    // Any byte count is accepted; illegal settings are not policed
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_r <= CNT_RST;
        end else if (apb_wr && !busy && paddr_i == CNT_OFS) begin
            count_r <= pwdata_i;
        end else if (xfer_end) begin
            count_r <= count_r - 32'(step_r);
        end
    end

    // Address trackers, fixed addresses never move
    dma_addr_track u_src (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .load_i     (start),
        .load_val_i (src_cfg_r),
        .adv_i      (xfer_end),
        .fixed_i    (ctrl_r[CTRL_SFIX_BIT]),
        .step_i     (step_r),
        .addr_o     (src_addr)
    );

    dma_addr_track u_dst (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .load_i     (start),
        .load_val_i (dst_cfg_r),
        .adv_i      (xfer_end && !flyby),
        .fixed_i    (ctrl_r[CTRL_DFIX_BIT]),
        .step_i     (step_r),
        .addr_o     (dst_addr)
    );

    dma_step_calc u_step (
        .src_len_i (src_len),
        .dst_len_i (dst_len),
        .flyby_i   (flyby),
        .no_opt_i  (no_opt_r),
        .src_off_i (src_addr[3:0]),
        .dst_off_i (dst_addr[3:0]),
        .count_i   (count_r),
        .step_o    (step_next)
    );

    // Lengths come from the start write itself; ctrl_r still holds the old ones
    assign new_slen = len_e'(pwdata_i[CTRL_SLEN_LSB +: 2]);
    assign new_dlen = len_e'(pwdata_i[CTRL_DLEN_LSB +: 2]);

    // Pairings without the optimisation fall back to bytes when unaligned
    always_comb begin
        blk_mask = (new_slen < new_dlen) ? 4'(5'(5'h01 << new_slen) - 5'h01)
                                         : 4'(5'(5'h01 << new_dlen) - 5'h01);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            no_opt_r <= 1'b0;
        end else if (start) begin
            no_opt_r <= (new_slen != LEN_BYTE) && (new_dlen != LEN_BYTE)
                        && !(new_slen == LEN_WORD && new_dlen == LEN_WORD)
                        && (new_slen != LEN_QUAD)
                        && (((src_cfg_r[3:0] | dst_cfg_r[3:0]) & blk_mask) != 4'h0);
        end
    end

    // Request handshake: each assertion is served at most once
    assign req_take = (state_r == S_WAIT) && dma_request_line_i && armed_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_r <= 1'b1;
        end else if (req_take) begin
            armed_r <= 1'b0;
        end else if (!dma_request_line_i) begin
            armed_r <= 1'b1;
        end
    end

    // Main sequence
    assign xfer_end = bus_done_i && ((state_r == S_STORE) || (state_r == S_FLY));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r      <= S_IDLE;
            wait_store_r <= 1'b0;
            step_r       <= STEP_BYTE;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (start) begin
                        state_r <= S_PICK;
                    end
                end
                S_PICK: begin
                    step_r       <= step_next;
                    wait_store_r <= 1'b0;
                    if (count_r == 32'h0000_0000) begin
                        state_r <= S_IDLE;
                    end else if (flyby) begin
                        state_r <= demand ? S_WAIT : S_FLY;
                    end else if (demand && src_sync) begin
                        state_r <= S_WAIT;
                    end else begin
                        state_r <= S_LOAD;
                    end
                end
                S_WAIT: begin
                    if (req_take) begin
                        if (flyby) begin
                            state_r <= S_FLY;
                        end else if (wait_store_r) begin
                            state_r <= S_STORE;
                        end else begin
                            state_r <= S_LOAD;
                        end
                    end
                end
                S_LOAD: begin
                    if (bus_done_i) begin
                        if (demand && !src_sync) begin
                            wait_store_r <= 1'b1;
                            state_r      <= S_WAIT;
                        end else begin
                            state_r <= S_STORE;
                        end
                    end
                end
                S_STORE, S_FLY: begin
                    if (bus_done_i) begin
                        state_r <= S_PICK;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Done is sticky; a new start clears it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_r <= 1'b0;
        end else if (state_r == S_PICK && count_r == 32'h0000_0000) begin
            done_r <= 1'b1;
        end else if (start) begin
            done_r <= 1'b0;
        end
    end

    // Acknowledge covers the whole request that answers the peripheral
    always_comb begin
        case (state_r)
            S_LOAD:  ack_phase = demand && src_sync;
            S_STORE: ack_phase = demand && !src_sync;
            S_FLY:   ack_phase = 1'b1;
            default: ack_phase = 1'b0;
        endcase
    end

    assign dma_acknowledge_line_o = ack_phase;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acks_r <= 32'h0000_0000;
        end else if (start) begin
            acks_r <= 32'h0000_0000;
        end else if (ack_phase && bus_done_i) begin
            acks_r <= acks_r + 32'h0000_0001;
        end
    end

    // Source bytes are steered to destination lanes; repeated reads are harmless
    always_comb begin
        rot_in  = {bus_rdata_i, bus_rdata_i} >> {src_addr[3:0], 3'b000};
        rot_out = {rot_in[127:0], rot_in[127:0]} << {dst_addr[3:0], 3'b000};
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_r <= 128'h0;
        end else if (state_r == S_LOAD && bus_done_i) begin
            hold_r <= rot_out[255:128];
        end
    end

    assign bus_wdata_o   = hold_r;
    assign bus_data_oe_o = (state_r == S_STORE);

    // Bus request; fly-by uses the source address only
    always_comb begin
        bus_req_o.valid = (state_r == S_LOAD) || (state_r == S_STORE) || (state_r == S_FLY);
        bus_req_o.write = (state_r == S_STORE)
                          || ((state_r == S_FLY) && ctrl_r[CTRL_FLYST_BIT]);
        bus_req_o.flyby = (state_r == S_FLY);
        bus_req_o.addr  = (state_r == S_STORE) ? dst_addr : src_addr;
        bus_req_o.bytes = step_r;
    end

endmodule

/* File: verification/dma_align_seq_properties.sv */
// Port assertions for the DMA alignment sequencer
`timescale 1ns/1ps
module dma_align_seq_properties
    import dma_align_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       dma_request_line_i,
    input  wire logic       dma_acknowledge_line_o,
    input  wire bus_req_s   bus_req_o,
    input  wire logic       bus_done_i,
    input  wire logic       bus_data_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic     ack;
    logic     vld;
    logic     armed_r;
    assign ack = dma_acknowledge_line_o;
    assign vld = bus_req_o.valid;
    // Request must drop before a second answer is legal
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_r <= 1'b1;
        end else if (!dma_request_line_i) begin
            armed_r <= 1'b1;
        end else if (ack) begin
            armed_r <= 1'b0;
        end
    end
    sequence s_open;
        vld && !bus_done_i;
    endsequence
    sequence s_ack_end;
        ack && bus_done_i;
    endsequence
    property p_ack_in_req;
        ack |-> vld;
    endproperty
    property p_ack_hold;
        s_open ##0 ack |=> ack;
    endproperty
    property p_ack_drop;
        s_ack_end |=> !ack;
    endproperty
    property p_ack_once;
        $rose(ack) |-> armed_r && $past(dma_request_line_i);
    endproperty
    property p_req_hold;
        s_open |=> $stable(bus_req_o);
    endproperty
    property p_step_size;
        vld |-> bus_req_o.bytes inside {5'h01, 5'h02, 5'h04, 5'h10};
    endproperty
    property p_step_align;
        vld |-> (bus_req_o.addr[4:0] & (bus_req_o.bytes - 5'h01)) == 5'h00;
    endproperty
    property p_flyby_float;
        vld && bus_req_o.flyby |-> !bus_data_oe_o;
    endproperty
    property p_store_drive;
        vld && bus_req_o.write && !bus_req_o.flyby |-> bus_data_oe_o;
    endproperty
    a_ack_in_req: assert property (p_ack_in_req) else $error("ack outside request");
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
    a_ack_drop: assert property (p_ack_drop) else $error("ack held past done");
    a_ack_once: assert property (p_ack_once) else $error("ack without fresh request");
    a_req_hold: assert property (p_req_hold) else $error("bus request changed");
    a_step_size: assert property (p_step_size) else $error("bad request size");
    a_step_align: assert property (p_step_align) else $error("request unaligned");
    a_flyby_float: assert property (p_flyby_float) else $error("fly-by drives data");
    a_store_drive: assert property (p_store_drive) else $error("store not driven");
endmodule

bind dma_align_seq dma_align_seq_properties i_props (
    .clk_i, .rst_n_i, .dma_request_line_i, .dma_acknowledge_line_o,
    .bus_req_o, .bus_done_i, .bus_data_oe_o
);

/* File: verification/dma_periph_model.sv */
// Requesting peripheral and bus controller responder
`timescale 1ns/1ps
module dma_periph_model
    import dma_align_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          en_i,
    input  wire logic          slow_i,
    input  wire logic          ack_i,
    input  wire bus_req_s      req_i,
    output logic               dma_request_line_o,
    output logic               done_o,
    output logic     [127:0]   rdata_o,
    output int                 n_req_o
);
    logic [1:0] lat_r;
    // Next request paced by the acknowledge, no assumed count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_request_line_o  <= 1'b0;
            n_req_o <= 0;
        end else if (dma_request_line_o && ack_i) begin
            dma_request_line_o  <= 1'b0;
            n_req_o <= n_req_o + 1;
        end else if (!en_i) begin
            dma_request_line_o <= 1'b0;
        end else if (!dma_request_line_o && !ack_i) begin
            dma_request_line_o <= 1'b1;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lat_r <= 2'h0;
        end else begin
            lat_r <= (req_i.valid && !done_o) ? lat_r + 2'h1 : 2'h0;
        end
    end
    assign done_o = req_i.valid && (!slow_i || lat_r == 2'h3);
    // Data follows the address, so rereads while aligning are harmless
    assign rdata_o = (req_i.valid && !req_i.write) ? {4{req_i.addr}} : ~{4{req_i.addr}};
endmodule

/* File: verification/dma_align_seq_tb_top.sv */
// Self-checking bench for the DMA alignment sequencer
`timescale 1ns/1ps
module dma_align_seq_tb_top;
    import dma_align_pkg::*;
    logic           clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic           dma_request_line, ack, bdone, oe, en, slow, perr;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata, q, la;
    logic [127:0]   brdata, wd;
    bus_req_s       breq;
    int             err_total, n_tests, n_req, base, moved;
    int             n_sz[32];

    dma_align_seq i_dut (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .dma_request_line_i(dma_request_line),
        .dma_acknowledge_line_o(ack), .bus_req_o(breq), .bus_done_i(bdone),
        .bus_rdata_i(brdata), .bus_wdata_o(wd), .bus_data_oe_o(oe));
    dma_periph_model i_peer (.clk_i(clk), .rst_n_i(rst_n), .en_i(en), .slow_i(slow),
        .ack_i(ack), .req_i(breq), .dma_request_line_o(dma_request_line), .done_o(bdone), .rdata_o(brdata),
        .n_req_o(n_req));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Sizes of all completed requests; bytes handed over per completed store or fly-by request
    always @(posedge clk) begin
        if (breq.valid && bdone) begin
            n_sz[breq.bytes]++;
            if (breq.write || breq.flyby) moved += breq.bytes;
        end
        // First source byte must land in the destination lane
        if (breq.valid && bdone && !breq.flyby) begin
            if (!breq.write) la = breq.addr;
            else chk(32'(wd[8*breq.addr[3:0] +: 8]), 32'(la[8*la[1:0] +: 8]));
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q    = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] cf(input logic [2:0] m, input len_e sl, input len_e dl,
                                       input logic [1:0] fx, input logic fs);
        return 32'({fs, fx, dl, sl, m, 1'b1});
    endfunction
    // Program, start, then poll done with a bounded count
    task automatic run(input logic [31:0] s, input logic [31:0] d, input logic [31:0] c,
                       input logic [31:0] ctl);
        int k;
        n_sz  = '{default: 0};
        moved = 0;
        base  = n_req;
        apb(1'b1, SRC_OFS, s);
        apb(1'b1, DST_OFS, d);
        apb(1'b1, CNT_OFS, c);
        apb(1'b1, CTRL_OFS, ctl);
        q = 32'h0;
        k = 0;
        while (q[STAT_DONE_BIT] !== 1'b1 && k < 3000) begin
            apb(1'b0, STAT_OFS, 32'h0);
            k++;
        end
        chk(q[1:0], 2'h2);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #1500000;
        err_total++;
        end_of_test();
    end

    initial begin
        {psel, penable, pwrite, en, slow} = 5'h00;
        paddr  = 8'h00;
        pwdata = 32'h0;
        rst_n  = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            chk(q, 32'h0);
        end
        apb(1'b1, 8'h18, 32'hFFFF_FFFF);
        chk(perr, 1'b1);
        apb(1'b0, 8'h18, 32'h0);
        chk(q, 32'h0);
        $display("test registers done");
        run(32'h1003, 32'h2005, 32'h7, cf(3'h0, LEN_BYTE, LEN_BYTE, 2'h0, 1'b0));
        apb(1'b0, SRC_OFS, 32'h0);
        chk(q, 32'h100A);
        apb(1'b0, DST_OFS, 32'h0);
        chk(q, 32'h200C);
        chk(moved, 7);
        $display("test odd count done");
        slow <= 1'b1;
        run(32'h201, 32'h305, 32'hC, cf(3'h0, LEN_WORD, LEN_WORD, 2'h0, 1'b0));
        chk(n_sz[4], 4);
        chk(n_sz[1], 8);
        slow <= 1'b0;
        run(32'h101, 32'h203, 32'h6, cf(3'h0, LEN_SHORT, LEN_WORD, 2'h0, 1'b0));
        chk(n_sz[1], 12);
        run(32'h400, 32'h800, 32'h20, cf(3'h0, LEN_QUAD, LEN_QUAD, 2'h0, 1'b0));
        chk(n_sz[16], 4);
        apb(1'b0, CNT_OFS, 32'h0);
        chk(q, 32'h0);
        run(32'h40, 32'h300, 32'h8, cf(3'h0, LEN_WORD, LEN_WORD, 2'h1, 1'b0));
        chk(n_sz[4], 4);
        apb(1'b0, SRC_OFS, 32'h0);
        chk(q, 32'h40);
        apb(1'b0, DST_OFS, 32'h0);
        chk(q, 32'h308);
        $display("test block pairings done");
        for (int i = 0; i < 4; i++) begin
            en <= 1'b1;
            if (i < 2) run(32'h201, 32'h303, 32'hC,
                           cf({i[0], 2'h1}, LEN_WORD, LEN_WORD, 2'h0, 1'b0));
            else run(32'h40, 32'h0, 32'h8,
                     cf({i[0], 2'h3}, LEN_WORD, LEN_WORD, 2'h1, i[0]));
            en <= 1'b0;
            apb(1'b0, ACKS_OFS, 32'h0);
            chk(q, 32'(n_req - base));
            chk(moved, (i < 2) ? 12 : 8);
            chk(32'(n_req - base >= ((i < 2) ? 3 : 2)), 32'h1);
            if (i > 1) begin
                apb(1'b0, SRC_OFS, 32'h0);
                chk(q, 32'h40);
                chk(n_sz[4], 2);
            end
        end
        $display("test demand and fly-by done");
        end_of_test();
    end
endmodule
